//--- liu_regs.vh
// Register map, field positions, reset values and timing counts of the long interval unit.
// Assumes a byte-wide special function register bus and a 32.768 kHz crystal input.
`ifndef LIU_REGS_VH
`define LIU_REGS_VH

`define LIU_ADDR_CONTROL 8'ha1
`define LIU_ADDR_FRACTION 8'ha2
`define LIU_ADDR_SECONDS 8'ha3
`define LIU_ADDR_MINUTES 8'ha4
`define LIU_ADDR_HOURS 8'ha5
`define LIU_ADDR_TARGET 8'ha6

`define LIU_RESET_BYTE 8'h00

`define LIU_BIT_TIMEBASE_RUN 0
`define LIU_BIT_COUNTER_RUN 1
`define LIU_BIT_MATCH_FLAG 2
`define LIU_BIT_ONE_SHOT 3
`define LIU_BIT_RATE_LO 4
`define LIU_BIT_RATE_HI 5

`define LIU_RATE_FRACTION 2'h0
`define LIU_RATE_SECONDS 2'h1
`define LIU_RATE_MINUTES 2'h2
`define LIU_RATE_HOURS 2'h3

`define LIU_FRACTION_MAX 8'h7f
`define LIU_SECONDS_MAX 8'h3b
`define LIU_MINUTES_MAX 8'h3b
`define LIU_HOURS_MAX 8'h17

`define LIU_XTAL_HZ 32768
`define LIU_FRACTION_HZ 128
`define LIU_XTAL_PER_FRACTION (`LIU_XTAL_HZ / `LIU_FRACTION_HZ)

`define LIU_IRQ_VECTOR 16'h0053

`endif

//--- liu_xtal_edge.v
// Two-flop synchroniser for the crystal pin with a rising-edge pulse behind it.
// Assumes the system clock runs much faster than the crystal.
`timescale 1ns/1ps
`default_nettype none
module liu_xtal_edge (
    input wire clk,
    input wire rst,
    input wire xtal_in,
    output wire rise
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    always @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= xtal_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise = sync_q & ~last_q;
endmodule
`default_nettype wire

//--- liu_wrap_count.v
// One timebase stage: counts steps from zero up to MAX, then wraps and reports the overflow.
// Assumes clear has priority over load, and load over step.
`timescale 1ns/1ps
`default_nettype none
module liu_wrap_count #(
    parameter [7:0] MAX = 8'h3b
) (
    input wire clk,
    input wire rst,
    input wire clr,
    input wire load,
    input wire [7:0] load_val,
    input wire step,
    output reg [7:0] count_q,
    output wire wrap
);
    assign wrap = step & (count_q == MAX);

    always @(posedge clk) begin
        if (rst || clr) begin
            count_q <= 8'h00;
        end else if (load) begin
            count_q <= load_val;
        end else if (wrap) begin
            count_q <= 8'h00;
        end else if (step) begin
            count_q <= count_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- liu_top.v
// Long interval unit: crystal-paced time of day counters and an 8-bit interval match counter.
// Assumes the core reaches it over a byte-wide register port and that the crystal is a pin.
//
// How it works
// - Rate select picks fraction tick, seconds, minutes or hours as interval clock.
// - Each overflow of the selected stage increments the interval counter.
// - Counter equal to target sets the match flag; software clears it.
// - Match flag with its interrupt enabled raises the interrupt request.
// - In power-down the enabled flag wakes the core, vector 0053 hex.
// - One-shot mode: a timeout clears counter run, stopping after one interval.
// - Repeat mode: the counter reloads at every timeout and keeps counting.
// - Counter run enables the interval counter; clearing it zeroes the counter.
// - Timebase run clocks the timebase; clearing it stops and zeroes it.
// - Time registers accept software writes only while timebase run is low.
// - Fraction counts every 1/128 s, wraps 127 to 0, advancing seconds.
// - Seconds count 0 to 59, wrap, and advance minutes.
// - Minutes count 0 to 59, wrap, and advance hours.
// - Hours count 0 to 23 and wrap to 0.
// - Timing derives from the crystal pin, not the core clock, surviving power-down.
`timescale 1ns/1ps
`default_nettype none
`include "liu_regs.vh"
module liu_top #(
    parameter XTAL_PER_FRACTION = `LIU_XTAL_PER_FRACTION
) (
    input wire clk,
    input wire rst,
    input wire xtal_in,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata,
    input wire irq_enable_prio2,
    input wire power_down,
    output wire irq_req,
    output wire wake_req,
    output wire [15:0] irq_vector
);
    reg timebase_run_q;
    reg counter_run_q;
    reg match_flag_q;
    reg one_shot_select_q;
    reg rate_sel_hi_q;
    reg rate_sel_lo_q;
    reg [7:0] target_q;
    reg [7:0] interval_q;
    reg [7:0] interval_d;
    reg [8:0] prescale_q;
    reg timeout_d;
    reg interval_step;

    wire xtal_rise;
    wire frac_tick;
    wire frac_wrap;
    wire sec_wrap;
    wire min_wrap;
    wire [7:0] frac_count;
    wire [7:0] sec_count;
    wire [7:0] min_count;
    wire [7:0] hour_count;
    wire wr_ctl;
    wire time_load_ok;
    wire [1:0] rate_sel;
    wire sel_ctl;
    wire sel_frac;
    wire sel_sec;
    wire sel_min;
    wire sel_hour;
    wire sel_target;
    wire load_frac;
    wire load_sec;
    wire load_min;
    wire load_hour;
    wire target_wr;
    wire timebase_clr;
    wire match_clr;
    wire [7:0] interval_inc;
    wire interval_hit;
    wire [7:0] ctl_read;
    reg [7:0] rd_mux;

    // Address decode; each strobe touches only the register that its address names, except that a control write stopping the timebase zeroes the time registers.
    assign sel_ctl = (sfr_addr == `LIU_ADDR_CONTROL);
    assign sel_frac = (sfr_addr == `LIU_ADDR_FRACTION);
    assign sel_sec = (sfr_addr == `LIU_ADDR_SECONDS);
    assign sel_min = (sfr_addr == `LIU_ADDR_MINUTES);
    assign sel_hour = (sfr_addr == `LIU_ADDR_HOURS);
    assign sel_target = (sfr_addr == `LIU_ADDR_TARGET);
    assign wr_ctl = sfr_wr && sel_ctl;
    assign target_wr = sfr_wr && sel_target;
    assign time_load_ok = sfr_wr && !timebase_run_q;
    assign load_frac = time_load_ok && sel_frac;
    assign load_sec = time_load_ok && sel_sec;
    assign load_min = time_load_ok && sel_min;
    assign load_hour = time_load_ok && sel_hour;
    assign rate_sel = {rate_sel_hi_q, rate_sel_lo_q};

    // The core clock may stop in power-down; pacing comes only from crystal edges.
    liu_xtal_edge u_edge (
        .clk(clk),
        .rst(rst),
        .xtal_in(xtal_in),
        .rise(xtal_rise)
    );

    // Prescaler from crystal edges to the 1/128 second tick. Nine bits hold the default
    // of 256 edges; only a crystal ratio above 512 would need a wider prescaler.
    localparam [8:0] PRESCALE_LAST = XTAL_PER_FRACTION[8:0] - 9'h001;
    assign frac_tick = timebase_run_q && xtal_rise && (prescale_q == PRESCALE_LAST);

    always @(posedge clk) begin
        if (rst || !timebase_run_q) begin
            prescale_q <= 9'h000;
        end else if (frac_tick) begin
            prescale_q <= 9'h000;
        end else if (xtal_rise) begin
            prescale_q <= prescale_q + 9'h001;
        end
    end

    liu_wrap_count #(.MAX(`LIU_FRACTION_MAX)) u_frac (
        .clk(clk),
        .rst(rst),
        .clr(timebase_clr),
        .load(load_frac),
        .load_val(sfr_wdata),
        .step(frac_tick),
        .count_q(frac_count),
        .wrap(frac_wrap)
    );

    liu_wrap_count #(.MAX(`LIU_SECONDS_MAX)) u_sec (
        .clk(clk),
        .rst(rst),
        .clr(timebase_clr),
        .load(load_sec),
        .load_val(sfr_wdata),
        .step(frac_wrap),
        .count_q(sec_count),
        .wrap(sec_wrap)
    );

    liu_wrap_count #(.MAX(`LIU_MINUTES_MAX)) u_min (
        .clk(clk),
        .rst(rst),
        .clr(timebase_clr),
        .load(load_min),
        .load_val(sfr_wdata),
        .step(sec_wrap),
        .count_q(min_count),
        .wrap(min_wrap)
    );

    liu_wrap_count #(.MAX(`LIU_HOURS_MAX)) u_hour (
        .clk(clk),
        .rst(rst),
        .clr(timebase_clr),
        .load(load_hour),
        .load_val(sfr_wdata),
        .step(min_wrap),
        .count_q(hour_count),
        .wrap()
    );

    // Stopping the timebase zeroes the time registers at the same edge as the stop write.
    // The clear is not registered, so a preload may follow the stop write back to back.
    // A control write while already stopped leaves a preloaded time untouched.
    assign timebase_clr = wr_ctl && timebase_run_q &&
        !sfr_wdata[`LIU_BIT_TIMEBASE_RUN];

    // Stage selection for the interval counter.
    always @* begin
        case (rate_sel)
            `LIU_RATE_FRACTION: interval_step = frac_tick;
            `LIU_RATE_SECONDS: interval_step = frac_wrap;
            `LIU_RATE_MINUTES: interval_step = sec_wrap;
            `LIU_RATE_HOURS: interval_step = min_wrap;
            default: interval_step = 1'b0;
        endcase
    end

    // The compare uses the incremented value, so a target of zero means 256 overflows.
    assign interval_inc = interval_q + 8'h01;
    assign interval_hit = (interval_inc == target_q);

    always @* begin
        interval_d = interval_q;
        timeout_d = 1'b0;
        if (!counter_run_q) begin
            interval_d = 8'h00;
        end else if (interval_step) begin
            if (interval_hit) begin
                timeout_d = 1'b1;
                interval_d = 8'h00;
            end else begin
                interval_d = interval_inc;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            interval_q <= 8'h00;
        end else begin
            interval_q <= interval_d;
        end
    end

    // Software clears the match flag by writing its bit as zero; a one leaves it alone.
    assign match_clr = wr_ctl && !sfr_wdata[`LIU_BIT_MATCH_FLAG];

    // Clearing timebase run also zeroes the prescaler, so a restart waits a full tick.
    always @(posedge clk) begin
        if (rst) begin
            timebase_run_q <= 1'b0;
        end else if (wr_ctl) begin
            timebase_run_q <= sfr_wdata[`LIU_BIT_TIMEBASE_RUN];
        end
    end

    // A one-shot timeout wins over a same-cycle write that sets counter run, so a single
    // interval never silently turns into a second one.
    always @(posedge clk) begin
        if (rst) begin
            counter_run_q <= 1'b0;
        end else if (timeout_d && one_shot_select_q) begin
            counter_run_q <= 1'b0;
        end else if (wr_ctl) begin
            counter_run_q <= sfr_wdata[`LIU_BIT_COUNTER_RUN];
        end
    end

    // The set wins over a clearing write in the same cycle, so no match is ever lost.
    always @(posedge clk) begin
        if (rst) begin
            match_flag_q <= 1'b0;
        end else if (timeout_d) begin
            match_flag_q <= 1'b1;
        end else if (match_clr) begin
            match_flag_q <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            one_shot_select_q <= 1'b0;
        end else if (wr_ctl) begin
            one_shot_select_q <= sfr_wdata[`LIU_BIT_ONE_SHOT];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rate_sel_hi_q <= 1'b0;
            rate_sel_lo_q <= 1'b0;
        end else if (wr_ctl) begin
            rate_sel_hi_q <= sfr_wdata[`LIU_BIT_RATE_HI];
            rate_sel_lo_q <= sfr_wdata[`LIU_BIT_RATE_LO];
        end
    end

    // Any byte is a legal target; zero asks for a full 256 overflows.
    always @(posedge clk) begin
        if (rst) begin
            target_q <= `LIU_RESET_BYTE;
        end else if (target_wr) begin
            target_q <= sfr_wdata;
        end
    end

    // Reserved control bits 7 and 6 are stored nowhere and read as zero.
    assign ctl_read = {2'b00, rate_sel_hi_q, rate_sel_lo_q, one_shot_select_q, match_flag_q,
        counter_run_q, timebase_run_q};

    // The read mux is combinational and the read data register latches it on a strobe,
    // so the byte stays put between reads even while the time registers count on.
    always @* begin
        case (sfr_addr)
            `LIU_ADDR_CONTROL: rd_mux = ctl_read;
            `LIU_ADDR_FRACTION: rd_mux = frac_count;
            `LIU_ADDR_SECONDS: rd_mux = sec_count;
            `LIU_ADDR_MINUTES: rd_mux = min_count;
            `LIU_ADDR_HOURS: rd_mux = hour_count;
            `LIU_ADDR_TARGET: rd_mux = target_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= rd_mux;
        end
    end

    // The request is a level from the flag, so it stands until software clears the flag
    // or the core masks it; waking needs nothing beyond this block's own clock.
    assign irq_req = match_flag_q && irq_enable_prio2;
    assign wake_req = irq_req && power_down;
    assign irq_vector = `LIU_IRQ_VECTOR;
endmodule
`default_nettype wire

//--- liu_monitor.sv
// Checker for the register port and interrupt outputs of the long interval unit.
// Assumes software only ever writes in-range time values.
`timescale 1ns/1ps
`default_nettype none
module liu_monitor (
    input wire clk,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    input wire [7:0] sfr_rdata,
    input wire irq_enable_prio2,
    input wire power_down,
    input wire irq_req,
    input wire wake_req,
    input wire [15:0] irq_vector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd(a); sfr_rd && sfr_addr == a; endsequence
    sequence s_tgt;
        sfr_wr && sfr_addr == 8'ha6 ##1 !sfr_wr ##1 sfr_rd && !sfr_wr && sfr_addr == 8'ha6;
    endsequence
    property p_vec; irq_vector == 16'h0053; endproperty
    property p_wake; wake_req == (irq_req && power_down); endproperty
    property p_en; !irq_enable_prio2 |-> !irq_req; endproperty
    property p_hold; irq_req && !(sfr_wr && sfr_addr == 8'ha1) ##1 irq_enable_prio2 |-> irq_req; endproperty
    property p_tgt; s_tgt |=> sfr_rdata == $past(sfr_wdata, 3); endproperty
    property p_ctl; s_rd(8'ha1) |=> sfr_rdata[7:6] == 2'b00; endproperty
    property p_frac; s_rd(8'ha2) |=> sfr_rdata <= 8'h7f; endproperty
    property p_sec; s_rd(8'ha3) |=> sfr_rdata <= 8'h3b; endproperty
    property p_min; s_rd(8'ha4) |=> sfr_rdata <= 8'h3b; endproperty
    property p_hr; s_rd(8'ha5) |=> sfr_rdata <= 8'h17; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    a_wake: assert property (p_wake) else $error("wake wrong");
    a_en: assert property (p_en) else $error("irq while disabled");
    a_hold: assert property (p_hold) else $error("flag dropped");
    a_tgt: assert property (p_tgt) else $error("target readback");
    a_ctl: assert property (p_ctl) else $error("reserved bits");
    a_frac: assert property (p_frac) else $error("fraction range");
    a_sec: assert property (p_sec) else $error("seconds range");
    a_min: assert property (p_min) else $error("minutes range");
    a_hr: assert property (p_hr) else $error("hours range");
endmodule
bind liu_top liu_monitor u_mon (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .irq_enable_prio2(irq_enable_prio2), .power_down(power_down), .irq_req(irq_req),
    .wake_req(wake_req), .irq_vector(irq_vector));
`default_nettype wire

//--- tb.sv
// Self-checking bench for the long interval unit.
// Assumes a prescaler shortened to four crystal edges per fraction tick.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, xtal_in = 0, sfr_wr = 0, sfr_rd = 0, rd_d = 0;
    logic irq_enable_prio2 = 1, power_down = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, exp_q[$];
    logic [31:0] seed = 32'h3c82e02f;
    wire [7:0] sfr_rdata;
    wire irq_req, wake_req;
    wire [15:0] irq_vector;
    string name_q[$];
    int n_mismatch = 0, checks_done = 0, t;
    always #5 clk = ~clk;
    liu_top #(.XTAL_PER_FRACTION(4)) dut (.clk(clk), .rst(rst), .xtal_in(xtal_in),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .irq_enable_prio2(irq_enable_prio2), .power_down(power_down),
        .irq_req(irq_req), .wake_req(wake_req), .irq_vector(irq_vector));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge clk) sfr_wr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(negedge clk) {sfr_addr, sfr_rd} = {a, 1'b1};
        exp_q.push_back(e);
        name_q.push_back(nm);
        @(negedge clk) sfr_rd = 0;
    endtask
    // Only crystal edges advance the timebase, never the core clock alone.
    task tick(input int n);
        repeat (n * 4) begin
            @(negedge clk) xtal_in = 1;
            repeat (3) @(negedge clk);
            xtal_in = 0;
            repeat (3) @(negedge clk);
        end
        repeat (8) @(negedge clk);
    endtask
    task irq(input logic e);
        check("irq_req", {7'h00, irq_req}, {7'h00, e});
    endtask
    // Read data lands one edge after the strobe, so it is taken at the following falling edge.
    always @(posedge clk) rd_d <= sfr_rd;
    always @(negedge clk) if (rd_d) check(name_q.pop_front(), sfr_rdata, exp_q.pop_front());
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        for (int a = 8'ha0; a < 8'ha8; a++) rd(a[7:0], 8'h00, "reset value");
        check("irq_vector high", irq_vector[15:8], 8'h00);
        check("irq_vector low", irq_vector[7:0], 8'h53);
        wr(8'ha2, 8'h7f);
        wr(8'ha3, 8'h3b);
        wr(8'ha4, 8'h3b);
        wr(8'ha5, 8'h17);
        rd(8'ha5, 8'h17, "hours preload");
        wr(8'ha1, 8'h41);
        tick(1);
        rd(8'ha2, 8'h00, "fraction");
        rd(8'ha3, 8'h00, "seconds");
        rd(8'ha4, 8'h00, "minutes");
        rd(8'ha5, 8'h00, "hours");
        wr(8'ha3, 8'h05);
        tick(1);
        rd(8'ha3, 8'h00, "seconds locked");
        rd(8'ha2, 8'h01, "fraction");
        wr(8'ha1, 8'h40);
        rd(8'ha2, 8'h00, "fraction stop");
        for (int r = 0; r < 4; r++) begin
            wr(8'ha1, 8'h40);
            wr(8'ha2, 8'h7e);
            wr(8'ha3, r >= 2 ? 8'h3b : 8'h00);
            wr(8'ha4, r == 3 ? 8'h3b : 8'h00);
            wr(8'ha6, r == 0 ? 8'h02 : 8'h01);
            wr(8'ha1, {2'b01, r[1:0], 4'h3});
            tick(1);
            irq(0);
            tick(1);
            irq(1);
        end
        seed = lfsr(seed);
        t = 1 + seed % 3;
        wr(8'ha1, 8'h40);
        wr(8'ha6, t[7:0]);
        rd(8'ha6, t[7:0], "target");
        wr(8'ha1, 8'h43);
        tick(t);
        rd(8'ha1, 8'h07, "control");
        @(negedge clk) irq_enable_prio2 = 0;
        #1 irq(0);
        @(negedge clk) {irq_enable_prio2, power_down} = 2'b11;
        #1 check("wake_req", {7'h00, wake_req}, 8'h01);
        power_down = 0;
        #1 check("wake_req", {7'h00, wake_req}, 8'h00);
        wr(8'ha1, 8'h43);
        irq(0);
        tick(t - 1);
        irq(0);
        tick(1);
        irq(1);
        wr(8'ha6, 8'h02);
        wr(8'ha1, 8'h43);
        tick(1);
        wr(8'ha1, 8'h41);
        wr(8'ha1, 8'h43);
        tick(1);
        irq(0);
        tick(1);
        irq(1);
        wr(8'ha6, 8'h01);
        wr(8'ha1, 8'h4b);
        tick(1);
        rd(8'ha1, 8'h0d, "one-shot control");
        wr(8'ha1, 8'h49);
        tick(2);
        irq(0);
        @(negedge clk) rst = 1;
        repeat (4) @(negedge clk);
        rst = 0;
        rd(8'ha1, 8'h00, "control after reset");
        irq(0);
        print_verdict;
    end
endmodule
`default_nettype wire
